//--- hdl/ivpt_core.sv
module ivpt_core #(
  parameter int HOLD_CYC = ivpt_pkg::RST_HOLD_CYC
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Maskable request pulses from peripherals (same clock).
  input wire logic timer_ch10_done_irq,
  input wire logic timer_ch11_done_irq,
  input wire logic timer_ch12_done_irq,
  input wire logic uart2_rx_error_irq,
  input wire logic adc_done_irq,
  input wire logic uart4_tx_irq,
  input wire logic csio_ch40_irq,
  input wire logic uart4_rx_irq,
  input wire logic csio_ch41_irq,
  // Core side: masks, enable, break, opcode trace.
  input wire logic [6:0] slotMask,
  input wire logic intEnable,
  input wire logic software_break,
  input wire logic opExecValid,
  input wire logic [7:0] opExecByte,
  input wire logic debugMode,
  // Reset sources.
  input wire logic resetPin_n,
  input wire logic power_on_clear_reset,
  input wire logic low_voltage_reset,
  input wire logic [7:0] low_voltage_detect_reg,
  input wire logic watchdog_overflow_reset,
  // Vector table read port.
  output logic vecRdReq,
  output logic [15:0] vecRdAddr,
  input wire logic vecRdValid,
  input wire logic [15:0] vecRdData,
  // Results toward the core.
  output logic coreRst,
  output logic intAccept,
  output logic [5:0] intPrio,
  output logic pcLoad,
  output logic [15:0] pcValue,
  output logic [6:0] pendingFlags,
  output logic [4:0] resetCause
);

  //========================================================================
  // Elaboration check.
  initial begin
    if (HOLD_CYC < 1 || HOLD_CYC > 65535) begin
      $error("HOLD_CYC out of range");
    end
  end

  //========================================================================
  // Lowest set index of a slot vector; 7 when none is set.
  function automatic logic [2:0] lowest(input logic [6:0] v);
    logic [2:0] idx;
    idx = 3'd7;
    for (int i = ivpt_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : lowest

  // Table lookup of a slot's vector address.
  function automatic logic [15:0] slotVec(input logic [2:0] s);
    logic [15:0] v;
    v = ivpt_pkg::RST_VEC;
    for (int i = 0; i < ivpt_pkg::NUM_SLOTS; i++) begin
      if (s == 3'(i)) begin
        v = ivpt_pkg::SLOT_VEC[i];
      end
    end
    return v;
  endfunction : slotVec

  //========================================================================
  // Asynchronous sources pass two flip-flops before use.
  logic [2:0] syncA_r;
  logic [2:0] syncB_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_r <= 3'h0;
      syncB_r <= 3'h0;
    end else begin
      syncA_r <= {low_voltage_reset, power_on_clear_reset, ~resetPin_n};
      syncB_r <= syncA_r;
    end
  end

  //========================================================================
  // Reset source qualification.
  wire pinRst = syncB_r[0];
  wire pocRst = syncB_r[1];
  wire lviRst = syncB_r[2] &&
    low_voltage_detect_reg[ivpt_pkg::LVI_MODE_BIT];
  wire wdtRst = watchdog_overflow_reset;
  wire trapRst = opExecValid && (opExecByte == ivpt_pkg::ILLEGAL_OP)
    && !debugMode;
  wire [4:0] causeNow = {trapRst, wdtRst, lviRst, pocRst, pinRst};
  wire anyRst = |causeNow;

  //========================================================================
  // Raw requests per slot; shared slots OR their two sources.
  wire [6:0] rawReq = {
    uart4_rx_irq | csio_ch41_irq,
    uart4_tx_irq | csio_ch40_irq,
    adc_done_irq,
    uart2_rx_error_irq,
    timer_ch12_done_irq,
    timer_ch11_done_irq,
    timer_ch10_done_irq
  };

  //========================================================================
  // State.
  ivpt_pkg::ivpt_state_e state_r;
  ivpt_pkg::ivpt_state_e state_nxt;
  logic [6:0] pend_r;
  logic brkPend_r;
  logic [15:0] holdCnt_r;
  logic [15:0] vecAddr_r;
  logic [4:0] cause_r;
  logic accept_r;
  logic [5:0] prio_r;
  logic load_r;
  logic [15:0] pcVal_r;

  //========================================================================
  // Arbitration: enabled, unmasked pending flags, lowest index wins.
  wire [6:0] eligible = pend_r & ~slotMask;
  wire [2:0] winIdx = lowest(eligible);
  wire haveWin = intEnable && (|eligible);
  wire takeBrk = (state_r == ivpt_pkg::IVPT_IDLE) &&
    (brkPend_r || software_break);
  wire takeInt = (state_r == ivpt_pkg::IVPT_IDLE) && !takeBrk && haveWin;
  wire [6:0] winOneHot = takeInt ? (7'h01 << winIdx) : 7'h00;
  wire holdDone = (holdCnt_r == 16'(HOLD_CYC - 1));

  //========================================================================
  // Next-state logic of the vector sequencer.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ivpt_pkg::IVPT_IDLE: begin
        if (takeBrk || takeInt) begin
          state_nxt = ivpt_pkg::IVPT_FETCH;
        end
      end
      ivpt_pkg::IVPT_HOLD: begin
        if (holdDone) begin
          state_nxt = ivpt_pkg::IVPT_FETCH;
        end
      end
      ivpt_pkg::IVPT_FETCH: begin
        if (vecRdValid) begin
          state_nxt = ivpt_pkg::IVPT_IDLE;
        end
      end
      default: state_nxt = ivpt_pkg::IVPT_IDLE;
    endcase
    // Any reset source preempts whatever is in progress.
    if (anyRst) begin
      state_nxt = ivpt_pkg::IVPT_HOLD;
    end
  end

  //========================================================================
  // Sequencer, hold counter and vector address.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ivpt_pkg::IVPT_HOLD;
      holdCnt_r <= 16'h0000;
      vecAddr_r <= ivpt_pkg::RST_VEC;
    end else begin
      state_r <= state_nxt;
      if (anyRst || state_r != ivpt_pkg::IVPT_HOLD) begin
        holdCnt_r <= 16'h0000;
      end else if (!holdDone) begin
        holdCnt_r <= holdCnt_r + 16'h0001;
      end
      if (anyRst) begin
        vecAddr_r <= ivpt_pkg::RST_VEC;
      end else if (takeBrk) begin
        vecAddr_r <= ivpt_pkg::BRK_VEC;
      end else if (takeInt) begin
        vecAddr_r <= slotVec(winIdx);
      end
    end
  end

  //========================================================================
  // Pending flags: a new request in the grant cycle survives the clear.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_r <= 7'h00;
      brkPend_r <= 1'b0;
    end else if (anyRst) begin
      pend_r <= 7'h00;
      brkPend_r <= 1'b0;
    end else begin
      pend_r <= (pend_r & ~winOneHot) | rawReq;
      brkPend_r <= (brkPend_r || software_break) && !takeBrk;
    end
  end

  //========================================================================
  // Reset cause capture, accumulated until the next reset event clears.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cause_r <= ivpt_pkg::CAUSE_RST;
    end else if (anyRst && state_r != ivpt_pkg::IVPT_HOLD) begin
      cause_r <= causeNow;
    end else if (anyRst) begin
      cause_r <= cause_r | causeNow;
    end
  end

  //========================================================================
  // Grant report and program counter load.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      accept_r <= 1'b0;
      prio_r <= 6'h00;
      load_r <= 1'b0;
      pcVal_r <= 16'h0000;
    end else begin
      accept_r <= takeInt && !anyRst;
      if (takeInt) begin
        prio_r <= ivpt_pkg::FIRST_PRIO + {3'h0, winIdx};
      end
      load_r <= (state_r == ivpt_pkg::IVPT_FETCH) && vecRdValid
        && !anyRst;
      if ((state_r == ivpt_pkg::IVPT_FETCH) && vecRdValid) begin
        pcVal_r <= vecRdData;
      end
    end
  end

  //========================================================================
  // Outputs. The core is held in reset until the reset vector is loaded.
  assign vecRdReq = (state_r == ivpt_pkg::IVPT_FETCH);
  assign vecRdAddr = vecAddr_r;
  assign coreRst = (state_r == ivpt_pkg::IVPT_HOLD) ||
    ((state_r == ivpt_pkg::IVPT_FETCH) &&
    (vecAddr_r == ivpt_pkg::RST_VEC));
  assign intAccept = accept_r;
  assign intPrio = prio_r;
  assign pcLoad = load_r;
  assign pcValue = pcVal_r;
  assign pendingFlags = pend_r;
  assign resetCause = cause_r;

endmodule : ivpt_core

//--- hdl/ivpt_pkg.sv
//==========================================================================
// What this block does
// - Simultaneous maskable requests: lowest priority number wins.
// - Timer channel 10: priority 41, vector 0056H.
// - Timer channel 11: priority 42, vector 0058H.
// - Timer channel 12: priority 43, vector 005AH.
// - UART2 receive error: priority 44, vector 005CH.
// - Conversion done: priority 45, vector 005EH.
// - UART4 transmit or channel 40: priority 46, 0060H.
// - UART4 receive or channel 41: priority 47, 0062H.
// - Software break: non-maskable, vector 007EH.
// - Watchdog overflow is a reset source.
// - Low voltage resets only when mode bit set.
// - Opcode FFH executed causes a reset.
// - No illegal-opcode reset under debug emulation.
package ivpt_pkg;

  //========================================================================
  // Maskable slots, ordered by default priority.
  localparam int NUM_SLOTS = 7;
  localparam logic [5:0] FIRST_PRIO = 6'h29;
  localparam logic [15:0] SLOT_VEC [NUM_SLOTS] = '{
    16'h0056, 16'h0058, 16'h005A, 16'h005C, 16'h005E, 16'h0060, 16'h0062
  };

  //========================================================================
  // Non-maskable and reset vectors.
  localparam logic [15:0] BRK_VEC = 16'h007E;
  localparam logic [15:0] RST_VEC = 16'h0000;
  localparam logic [7:0] ILLEGAL_OP = 8'hFF;
  localparam int LVI_MODE_BIT = 1;

  //========================================================================
  // Reset cause bit positions.
  localparam int CAUSE_PIN = 0;
  localparam int CAUSE_POC = 1;
  localparam int CAUSE_LVI = 2;
  localparam int CAUSE_WDT = 3;
  localparam int CAUSE_TRAP = 4;
  localparam int NUM_CAUSES = 5;
  localparam logic [4:0] CAUSE_RST = 5'h00;

  //========================================================================
  // Internal reset stretch.
  localparam int RST_HOLD_CYC = 16;

  //========================================================================
  // Sequencer states.
  typedef enum logic [1:0] {
    IVPT_IDLE = 2'b00,
    IVPT_HOLD = 2'b01,
    IVPT_FETCH = 2'b10
  } ivpt_state_e;

endpackage : ivpt_pkg

//--- tb/ivpt_core_sva.sv
//=====================================================================
// Checker on the sequencer ports: grants, vectors, fetch and reset.
module ivpt_core_sva #(
  parameter int HOLD_CYC = 2
) (
  // Clock, reset and inputs.
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [6:0] slotMask,
  input wire logic watchdog_overflow_reset,
  input wire logic vecRdValid,
  input wire logic [15:0] vecRdData,
  // Outputs.
  input wire logic vecRdReq,
  input wire logic [15:0] vecRdAddr,
  input wire logic coreRst,
  input wire logic intAccept,
  input wire logic [5:0] intPrio,
  input wire logic pcLoad,
  input wire logic [15:0] pcValue,
  input wire logic [6:0] pendingFlags
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Winner as one-hot; (win << 1) - 1 covers it and every slot ranked above.
  wire [6:0] win = 7'h01 << (intPrio - 6'h29);
  wire [6:0] elig = pendingFlags & ~slotMask;
  sequence s_take; vecRdReq && vecRdValid; endsequence
  property p_win; intAccept |->
    ($past(elig) & ((win << 1) - 7'h01)) == win; endproperty
  property p_addr; intAccept |->
    vecRdReq && vecRdAddr == {9'h000, intPrio, 1'b0} + 16'h0004; endproperty
  property p_hold; vecRdReq && !vecRdValid |=>
    coreRst || (vecRdReq && $stable(vecRdAddr)); endproperty
  property p_load; s_take |=>
    pcLoad && pcValue == $past(vecRdData); endproperty
  property p_rvec; coreRst && vecRdReq |-> vecRdAddr == 16'h0000; endproperty
  property p_brk; $rose(vecRdReq) && !intAccept && !coreRst |->
    vecRdAddr == 16'h007E; endproperty
  property p_rel; $fell(coreRst) |-> pcLoad; endproperty
  property p_wdt; watchdog_overflow_reset |=> coreRst; endproperty
  a_win: assert property (p_win) else $error("wrong winner");
  a_addr: assert property (p_addr) else $error("bad vector");
  a_hold: assert property (p_hold) else $error("fetch dropped");
  a_load: assert property (p_load) else $error("bad pc load");
  a_rvec: assert property (p_rvec) else $error("bad reset vector");
  a_brk: assert property (p_brk) else $error("bad break vector");
  a_rel: assert property (p_rel) else $error("early release");
  a_wdt: assert property (p_wdt) else $error("no wdt reset");
endmodule : ivpt_core_sva

bind ivpt_core ivpt_core_sva #(.HOLD_CYC(HOLD_CYC)) u_sva (.*);

//--- tb/ivpt_vec_mem.sv
//=====================================================================
// Vector table model answering the fetch port.
module ivpt_vec_mem (
  // Clock, reset and pacing.
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic slow,
  // Fetch port.
  input wire logic vecRdReq,
  input wire logic [15:0] vecRdAddr,
  output logic vecRdValid,
  output logic [15:0] vecRdData
);
  logic [1:0] waitCnt_r;
  // Between answers the inverse word shows, so stale data never matches.
  wire busy = vecRdReq && !vecRdValid;
  wire due = waitCnt_r == {slow, slow};
  assign vecRdData = vecRdValid ? vecRdAddr ^ 16'hC3C3 : vecRdAddr ^ 16'h3C3C;
  // Answer after one cycle, or four when slow, as a one-cycle pulse.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      waitCnt_r <= 2'h0;
      vecRdValid <= 1'b0;
    end else begin
      vecRdValid <= busy && due;
      waitCnt_r <= (busy && !due) ? waitCnt_r + 2'h1 : 2'h0;
    end
  end
endmodule : ivpt_vec_mem

//--- tb/interrupt_vector_priority_table_test.sv
//=====================================================================
// Bench: queues expected vector words, a monitor checks each load.
module interrupt_vector_priority_table_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, sys_rst = 1'b1, intEnable = 1'b0, slow = 1'b0;
  logic debugMode = 1'b0;
  logic [7:0] opExecByte = 8'hFF, low_voltage_detect_reg = 8'h00;
  logic [6:0] slotMask = 7'h00, pendingFlags, m;
  logic [9:0] src = 10'h000;
  logic [4:0] rs = 5'h00, resetCause;
  logic vecRdReq, vecRdValid, coreRst, intAccept, pcLoad;
  logic [15:0] vecRdAddr, vecRdData, pcValue, expQ[$];
  logic [5:0] intPrio;
  logic [31:0] rnd = 32'h0001_5B53;
  int n_fail = 0, samples_checked = 0, cyc = 0, s;
  // Requests, break and reset sources as bit vectors.
  wire timer_ch10_done_irq = src[0], timer_ch11_done_irq = src[1];
  wire timer_ch12_done_irq = src[2], uart2_rx_error_irq = src[3];
  wire adc_done_irq = src[4], uart4_tx_irq = src[5], csio_ch40_irq = src[6];
  wire uart4_rx_irq = src[7], csio_ch41_irq = src[8], software_break = src[9];
  wire resetPin_n = !rs[0], power_on_clear_reset = rs[1];
  wire low_voltage_reset = rs[2], watchdog_overflow_reset = rs[3];
  wire opExecValid = rs[4];
  ivpt_core #(.HOLD_CYC(2)) DUT (.*);
  ivpt_vec_mem u_mem (.*);
  // Clock at 200 MHz.
  initial forever #2.5 mclk = ~mclk;
  // Load monitor and hang guard.
  always @(posedge mclk) begin
    cyc++;
    #1;
    if (pcLoad === 1'b1) chk("pcValue", pcValue, expQ.pop_front());
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  // Queue the word behind a vector address and wait for its load.
  task automatic load(input logic [15:0] a);
    int k;
    expQ.push_back(a ^ 16'hC3C3);
    for (k = 0; k < 300 && pcLoad !== 1'b1; k++) @(negedge mclk);
    chk("pcLoad", {15'h0000, pcLoad}, 16'h0001);
    @(negedge mclk);
  endtask : load
  // Xorshift step; the seed above gives repeatable masks and pacing.
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    y = y ^ (y << 5);
    return y;
  endfunction : xorshift
  task automatic pulse(input logic [9:0] v);
    src = v;
    @(negedge mclk);
    src = 10'h000;
  endtask : pulse
  // Main sequence; all stimulus changes at the falling edge.
  initial begin
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    load(16'h0000);
    intEnable = 1'b1;
    for (int b = 0; b < 9; b++) begin
      s = (b < 5) ? b : ((b < 7) ? 5 : 6);
      pulse(10'h001 << b);
      load(16'(16'h0056 + 2 * s));
      chk("intPrio", {10'h000, intPrio}, 16'(16'h0029 + s));
    end
    $display("single sources done");
    repeat (4) begin
      rnd = xorshift(rnd);
      {slow, m} = rnd[7:0];
      slotMask = m;
      intEnable = 1'b0;
      pulse(10'h1FF);
      intEnable = 1'b1;
      for (s = 0; s < 7; s++) if (!m[s]) load(16'(16'h0056 + 2 * s));
      chk("pending", {9'h000, pendingFlags}, {9'h000, m});
      slotMask = 7'h00;
      for (s = 0; s < 7; s++) if (m[s]) load(16'(16'h0056 + 2 * s));
    end
    $display("priority and mask done");
    intEnable = 1'b0;
    pulse(10'h100);
    pulse(10'h200);
    intEnable = 1'b1;
    load(16'h007E);
    load(16'h0062);
    $display("break done");
    debugMode = 1'b1;
    rs = 5'h10;
    repeat (3) @(negedge mclk);
    opExecByte = 8'hFE;
    debugMode = 1'b0;
    repeat (3) @(negedge mclk);
    rs = 5'h04;
    repeat (3) @(negedge mclk);
    rs = 5'h00;
    repeat (8) @(negedge mclk);
    chk("cause", {11'h000, resetCause}, 16'h0000);
    opExecByte = 8'hFF;
    low_voltage_detect_reg = 8'h02;
    for (int r = 0; r < 5; r++) begin
      rs = 5'h01 << r;
      repeat (3) @(negedge mclk);
      rs = 5'h00;
      load(16'h0000);
      chk("cause", {11'h000, resetCause}, 16'h0001 << r);
    end
    $display("reset sources done");
    end_sim();
  end
endmodule : interrupt_vector_priority_table_test
